// ===== hdl/fio_defines.svh
// Purpose: Constants for the forced I/O override unit
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes: Point indices are linear: base block first, then expansion blocks
`ifndef FIO_DEFINES_SVH
`define FIO_DEFINES_SVH

// ----------------------------------------------------------------
// Point counts
// ----------------------------------------------------------------
`define FIO_NUM_IN 120
`define FIO_NUM_OUT 72
`define FIO_IN_BITS 128
`define FIO_OUT_BITS 96
`define FIO_OUT_WORDS 3
`define FIO_IN_MASK {8'h00, {120{1'b1}}}
`define FIO_OUT_MASK {24'h000000, {72{1'b1}}}

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FIO_ADR_CTRL 8'h00
`define FIO_ADR_STAT 8'h04
`define FIO_ADR_IN_DESIG 8'h10
`define FIO_ADR_IN_VALUE 8'h20
`define FIO_ADR_OUT_DESIG 8'h30
`define FIO_ADR_OUT_VALUE 8'h40
`define FIO_ADR_IN_IMAGE 8'h50
`define FIO_ADR_OUT_IMAGE 8'h60

// ----------------------------------------------------------------
// Control bits, write one to act
// ----------------------------------------------------------------
`define FIO_CTRL_TOGGLE 0
`define FIO_CTRL_RELEASE_ALL 1
`define FIO_CTRL_CLEAR_ALL 2
`define FIO_CTRL_SYS_DL 3
`define FIO_CTRL_PROG_DL 4
`define FIO_CTRL_DL_SUSPEND 5

// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define FIO_STAT_ACTIVE 0
`define FIO_STAT_ANY 1
`define FIO_STAT_RUNNING 2

// ----------------------------------------------------------------
// Special input points and reset values
// ----------------------------------------------------------------
`define FIO_STOP_PT 1
`define FIO_RESET_PT 2
`define FIO_ACTIVE_RST 1'b0

`endif

// ===== hdl/fio_pkg.sv
// Purpose: Types for the forced I/O override unit
// Assumes: fio_defines.svh supplies the widths
// Notes: Types only; numbers live in the header
`include "fio_defines.svh"

package fio_pkg;

  // ----------------------------------------------------------------
  // Scan and system event carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic inRefresh;
    logic outRefresh;
    logic running;
    logic maintainOutputsOnStopFlag;
  } fio_scan_t;

  typedef struct packed {
    logic powerUp;
    logic batteryFail;
  } fio_sys_t;

  typedef enum logic [3:0] {
    FIO_REG_CTRL,
    FIO_REG_STAT,
    FIO_REG_IN_DESIG,
    FIO_REG_IN_VALUE,
    FIO_REG_OUT_DESIG,
    FIO_REG_OUT_VALUE,
    FIO_REG_IN_IMAGE,
    FIO_REG_OUT_IMAGE,
    FIO_REG_NONE
  } fio_reg_t;

endpackage : fio_pkg

// ===== hdl/fio_image.sv
// Purpose: One scan image register with force substitution
// Assumes: load is a one-cycle refresh strobe
// Notes: Image changes only on load, so a whole scan sees one image
`timescale 1ns/1ps

module fio_image #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic active,
  input wire logic [W-1:0] desig,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] base,
  input wire logic baseValid,
  input wire logic keepPrev,
  output logic [W-1:0] image
);

  logic [W-1:0] image_r;
  logic [W-1:0] image_nxt;
  logic [W-1:0] normal;
  logic [W-1:0] forceSel;

  // ----------------------------------------------------------------
  // Substitution
  // ----------------------------------------------------------------
  always_comb begin
    // Suspended forcing leaves designated points on their normal value
    forceSel = active ? desig : '0;
    if (baseValid) begin
      normal = base;
    end else if (keepPrev) begin
      normal = image_r;
    end else begin
      normal = '0;
    end
    // Forced value replaces the normal one, even with no valid base
    image_nxt = image_r;
    if (load) begin
      image_nxt = (forceSel & value) | (~forceSel & normal);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      image_r <= '0;
    end else begin
      image_r <= image_nxt;
    end
  end

  assign image = image_r;

endmodule : fio_image

// ===== hdl/fio_override.sv
// Purpose: Forced I/O override unit for a controller's discrete I/O image
// Assumes: Classic Wishbone slave, 40 MHz clk, synchronous active-high rst
// Notes: Scan strobes come from the scan sequencer; one-cycle ack
//
// Function
// - Each input and output point has its own designation and forced value.
// - Covers base inputs 0-35 octal, outputs 0-21, plus three expansion blocks.
// - Active forcing replaces terminal state or program result with forced value.
// - Run/stop keeps designations; forced outputs hold regardless of maintain flag.
// - Power-up keeps designations but suspends forcing.
// - Power-up with failed battery erases all designations.
// - Program download keeps designations; downloader chooses suspension.
// - Reset input, clear-all or system software download erase designations.
// - Counter, catch and interrupt inputs see physical signals only.
// - Stop and reset inputs may be forced; forced reset erases designations.
// - Suspended forcing uses actual inputs and program outputs.
// - Each start/suspend command toggles forcing, designations untouched.
// - Designation stays until released; released point behaves normally.
// - One command releases every designation at once.
// - Forcing running or stopped is readable status and an indicator.
//
// Design decisions made here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "fio_defines.svh"

module fio_override
  import fio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // Scan and system
  input wire fio_scan_t scan,
  input wire fio_sys_t sys,
  input wire logic [`FIO_NUM_IN-1:0] physIn,
  input wire logic [`FIO_NUM_OUT-1:0] progOut,
  output logic [`FIO_NUM_IN-1:0] inImage,
  output logic [`FIO_NUM_OUT-1:0] outDrive,
  output logic [`FIO_NUM_IN-1:0] fastIn,
  output logic stopReq,
  output logic forceRunning
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic fio_reg_t regOf(input logic [7:0] adr);
    fio_reg_t r;
    r = FIO_REG_NONE;
    if (adr == `FIO_ADR_CTRL) begin
      r = FIO_REG_CTRL;
    end else if (adr == `FIO_ADR_STAT) begin
      r = FIO_REG_STAT;
    end else if ({adr[7:4], 4'h0} == `FIO_ADR_IN_DESIG) begin
      r = FIO_REG_IN_DESIG;
    end else if ({adr[7:4], 4'h0} == `FIO_ADR_IN_VALUE) begin
      r = FIO_REG_IN_VALUE;
    end else if ({adr[7:4], 4'h0} == `FIO_ADR_IN_IMAGE) begin
      r = FIO_REG_IN_IMAGE;
    end else if (adr[3:2] != 2'h3) begin
      if ({adr[7:4], 4'h0} == `FIO_ADR_OUT_DESIG) begin
        r = FIO_REG_OUT_DESIG;
      end else if ({adr[7:4], 4'h0} == `FIO_ADR_OUT_VALUE) begin
        r = FIO_REG_OUT_VALUE;
      end else if ({adr[7:4], 4'h0} == `FIO_ADR_OUT_IMAGE) begin
        r = FIO_REG_OUT_IMAGE;
      end
    end
    // Only word-aligned addresses map
    if (adr[1:0] != 2'h0) begin
      r = FIO_REG_NONE;
    end
    return r;
  endfunction : regOf

  function automatic logic [31:0] beMerge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction : beMerge

  // Effective level of an input point as the program would see it
  function automatic logic effIn(
    input logic act,
    input logic dsg,
    input logic val,
    input logic phy
  );
    return (act && dsg) ? val : phy;
  endfunction : effIn

  // ----------------------------------------------------------------
  // Force state
  // ----------------------------------------------------------------
  logic [`FIO_IN_BITS-1:0] inDesig_r;
  logic [`FIO_IN_BITS-1:0] inDesig_nxt;
  logic [`FIO_IN_BITS-1:0] inValue_r;
  logic [`FIO_IN_BITS-1:0] inValue_nxt;
  logic [`FIO_OUT_BITS-1:0] outDesig_r;
  logic [`FIO_OUT_BITS-1:0] outDesig_nxt;
  logic [`FIO_OUT_BITS-1:0] outValue_r;
  logic [`FIO_OUT_BITS-1:0] outValue_nxt;
  logic forceActive_r;
  logic forceActive_nxt;
  logic [`FIO_NUM_IN-1:0] fastIn_nxt;
  logic [`FIO_NUM_IN-1:0] fastInReg_r;
  logic stopReq_r;
  logic stopReq_nxt;
  logic forceRunning_r;

  logic wrReq;
  fio_reg_t wrReg;
  logic [1:0] wrWord;
  logic [31:0] ctrlBits;
  logic resetEff;
  logic eraseAll;

  assign wrReq = wbCyc && wbStb && wbWe && !wbAck;
  assign wrReg = regOf(wbAdr);
  assign wrWord = wbAdr[3:2];
  assign ctrlBits = (wrReq && wrReg == FIO_REG_CTRL) ? (wbDatI & {{24{1'b0}}, wbSel[0] ? 8'hff : 8'h00}) : 32'h0;

  // Reset input acts on its effective level, so forcing it on erases at once
  assign resetEff = effIn(forceActive_r, inDesig_r[`FIO_RESET_PT], inValue_r[`FIO_RESET_PT],
    physIn[`FIO_RESET_PT]);

  always_comb begin
    eraseAll = resetEff || ctrlBits[`FIO_CTRL_CLEAR_ALL] || ctrlBits[`FIO_CTRL_SYS_DL];
    if (sys.powerUp && sys.batteryFail) begin
      eraseAll = 1'b1;
    end
  end

  always_comb begin
    inDesig_nxt = inDesig_r;
    inValue_nxt = inValue_r;
    outDesig_nxt = outDesig_r;
    outValue_nxt = outValue_r;
    forceActive_nxt = forceActive_r;
    // Word writes set or release single points; other words are untouched
    if (wrReq) begin
      case (wrReg)
        FIO_REG_IN_DESIG: begin
          inDesig_nxt[wrWord*32 +: 32] = beMerge(inDesig_r[wrWord*32 +: 32], wbDatI, wbSel);
        end
        FIO_REG_IN_VALUE: begin
          inValue_nxt[wrWord*32 +: 32] = beMerge(inValue_r[wrWord*32 +: 32], wbDatI, wbSel);
        end
        FIO_REG_OUT_DESIG: begin
          outDesig_nxt[wrWord*32 +: 32] = beMerge(outDesig_r[wrWord*32 +: 32], wbDatI, wbSel);
        end
        FIO_REG_OUT_VALUE: begin
          outValue_nxt[wrWord*32 +: 32] = beMerge(outValue_r[wrWord*32 +: 32], wbDatI, wbSel);
        end
        default: begin
        end
      endcase
    end
    // Toggling touches only the active flag, never the point lists
    if (ctrlBits[`FIO_CTRL_TOGGLE]) begin
      forceActive_nxt = !forceActive_r;
    end
    // Download keeps the lists; the downloader decides on suspension
    if (ctrlBits[`FIO_CTRL_PROG_DL] && ctrlBits[`FIO_CTRL_DL_SUSPEND]) begin
      forceActive_nxt = 1'b0;
    end
    if (sys.powerUp) begin
      forceActive_nxt = 1'b0;
    end
    if (ctrlBits[`FIO_CTRL_RELEASE_ALL]) begin
      inDesig_nxt = '0;
      outDesig_nxt = '0;
    end
    // Hardware erase wins over a designation written in the same cycle
    if (eraseAll) begin
      inDesig_nxt = '0;
      outDesig_nxt = '0;
      inValue_nxt = '0;
      outValue_nxt = '0;
    end
    // Points beyond the largest model never exist
    inDesig_nxt = inDesig_nxt & `FIO_IN_MASK;
    inValue_nxt = inValue_nxt & `FIO_IN_MASK;
    outDesig_nxt = outDesig_nxt & `FIO_OUT_MASK;
    outValue_nxt = outValue_nxt & `FIO_OUT_MASK;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      inDesig_r <= '0;
      inValue_r <= '0;
      outDesig_r <= '0;
      outValue_r <= '0;
      forceActive_r <= `FIO_ACTIVE_RST;
    end else begin
      inDesig_r <= inDesig_nxt;
      inValue_r <= inValue_nxt;
      outDesig_r <= outDesig_nxt;
      outValue_r <= outValue_nxt;
      forceActive_r <= forceActive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scan images
  // ----------------------------------------------------------------
  logic [`FIO_NUM_IN-1:0] inImg;
  logic [`FIO_NUM_OUT-1:0] outImg;

  fio_image #(
    .W(`FIO_NUM_IN)
  ) uInImage (
    .clk(clk),
    .rst(rst),
    .load(scan.inRefresh),
    .active(forceActive_r),
    .desig(inDesig_r[`FIO_NUM_IN-1:0]),
    .value(inValue_r[`FIO_NUM_IN-1:0]),
    .base(physIn),
    .baseValid(1'b1),
    .keepPrev(1'b0),
    .image(inImg)
  );

  // Stopped: unforced outputs go off or hold per the maintain flag,
  // forced ones keep their value in either case
  fio_image #(
    .W(`FIO_NUM_OUT)
  ) uOutImage (
    .clk(clk),
    .rst(rst),
    .load(scan.outRefresh),
    .active(forceActive_r),
    .desig(outDesig_r[`FIO_NUM_OUT-1:0]),
    .value(outValue_r[`FIO_NUM_OUT-1:0]),
    .base(progOut),
    .baseValid(scan.running),
    .keepPrev(scan.maintainOutputsOnStopFlag),
    .image(outImg)
  );

  assign inImage = inImg;
  assign outDrive = outImg;

  // ----------------------------------------------------------------
  // Physical taps and indicators
  // ----------------------------------------------------------------
  always_comb begin
    // Fast functions bypass forcing entirely
    fastIn_nxt = physIn;
    stopReq_nxt = effIn(forceActive_r, inDesig_r[`FIO_STOP_PT], inValue_r[`FIO_STOP_PT],
      physIn[`FIO_STOP_PT]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fastInReg_r <= '0;
      stopReq_r <= 1'b0;
      forceRunning_r <= 1'b0;
    end else begin
      fastInReg_r <= fastIn_nxt;
      stopReq_r <= stopReq_nxt;
      forceRunning_r <= forceActive_nxt;
    end
  end

  assign fastIn = fastInReg_r;
  assign stopReq = stopReq_r;
  assign forceRunning = forceRunning_r;

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  logic wbAck_r;
  logic wbAck_nxt;
  logic [31:0] wbDatO_r;
  logic [31:0] wbDatO_nxt;
  logic [`FIO_IN_BITS-1:0] inImgWide;
  logic [`FIO_OUT_BITS-1:0] outImgWide;

  assign inImgWide = {{(`FIO_IN_BITS-`FIO_NUM_IN){1'b0}}, inImg};
  assign outImgWide = {{(`FIO_OUT_BITS-`FIO_NUM_OUT){1'b0}}, outImg};

  always_comb begin
    // Single-cycle answer; ack drops in the cycle after it was given
    wbAck_nxt = wbCyc && wbStb && !wbAck_r;
    wbDatO_nxt = 32'h0;
    if (wbCyc && wbStb && !wbWe && !wbAck_r) begin
      case (wrReg)
        FIO_REG_STAT: begin
          wbDatO_nxt[`FIO_STAT_ACTIVE] = forceActive_r;
          wbDatO_nxt[`FIO_STAT_ANY] = |{inDesig_r, outDesig_r};
          wbDatO_nxt[`FIO_STAT_RUNNING] = scan.running;
        end
        FIO_REG_IN_DESIG: begin
          wbDatO_nxt = inDesig_r[wrWord*32 +: 32];
        end
        FIO_REG_IN_VALUE: begin
          wbDatO_nxt = inValue_r[wrWord*32 +: 32];
        end
        FIO_REG_OUT_DESIG: begin
          wbDatO_nxt = outDesig_r[wrWord*32 +: 32];
        end
        FIO_REG_OUT_VALUE: begin
          wbDatO_nxt = outValue_r[wrWord*32 +: 32];
        end
        FIO_REG_IN_IMAGE: begin
          wbDatO_nxt = inImgWide[wrWord*32 +: 32];
        end
        FIO_REG_OUT_IMAGE: begin
          wbDatO_nxt = outImgWide[wrWord*32 +: 32];
        end
        default: begin
          // Control reads as zero, unmapped answers zero
          wbDatO_nxt = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wbAck_r <= 1'b0;
      wbDatO_r <= 32'h0;
    end else begin
      wbAck_r <= wbAck_nxt;
      wbDatO_r <= wbDatO_nxt;
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatO = wbDatO_r;

endmodule : fio_override

// ===== verif/fio_override_properties.sv
// Purpose: Concurrent checks on the forced I/O override unit ports
// Assumes: Single clock domain, synchronous active-high rst
// Notes: Bound to fio_override below the module
`timescale 1ns/1ps
`include "fio_defines.svh"

module fio_override_properties
  import fio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic wbAck,
  input wire fio_scan_t scan,
  input wire fio_sys_t sys,
  input wire logic [`FIO_NUM_IN-1:0] physIn,
  input wire logic [`FIO_NUM_OUT-1:0] progOut,
  input wire logic [`FIO_NUM_IN-1:0] inImage,
  input wire logic [`FIO_NUM_OUT-1:0] outDrive,
  input wire logic [`FIO_NUM_IN-1:0] fastIn,
  input wire logic stopReq,
  input wire logic forceRunning
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----
  // Steps
  // ----
  // Power-up must not land in the same write, it would outrank the command
  sequence ctrlWr(logic [5:0] b);
    wbCyc && wbStb && !wbAck && wbWe && wbAdr == `FIO_ADR_CTRL && wbSel[0]
      && wbDatI[5:0] == b && !sys.powerUp;
  endsequence
  sequence suspIn;
    scan.inRefresh && !forceRunning;
  endsequence
  sequence suspOut;
    scan.outRefresh && !forceRunning;
  endsequence

  // ----
  // Checks
  // ----
  AST_IN_HOLD: assert property (!scan.inRefresh |=> $stable(inImage))
    else $error("input image moved without refresh");
  AST_OUT_HOLD: assert property (!scan.outRefresh |=> $stable(outDrive))
    else $error("output image moved without refresh");
  AST_FAST: assert property (!$past(rst) |-> fastIn == $past(physIn))
    else $error("fast inputs differ from physical inputs");
  AST_SUSP_IN: assert property (suspIn |=> inImage == $past(physIn))
    else $error("suspended input image not physical");
  AST_SUSP_OUT: assert property (suspOut ##0 scan.running |=> outDrive == $past(progOut))
    else $error("suspended output image not program result");
  AST_STOP_HOLD: assert property (suspOut ##0 !scan.running
    ##0 scan.maintainOutputsOnStopFlag |=> $stable(outDrive))
    else $error("outputs not maintained on stop");
  AST_PWRUP: assert property (sys.powerUp |=> !forceRunning)
    else $error("forcing active after power-up");
  AST_TOGGLE: assert property (ctrlWr(6'h01) |=> forceRunning != $past(forceRunning))
    else $error("toggle did not flip forcing");
  AST_DL_SUSP: assert property (ctrlWr(6'h30) |=> !forceRunning)
    else $error("download with suspend left forcing on");
  AST_DL_KEEP: assert property (ctrlWr(6'h10) |=> $stable(forceRunning))
    else $error("plain download changed forcing");
  // Status word was built in the request cycle, so compare with that cycle's indicator
  AST_STAT: assert property (wbAck && !wbWe && wbAdr == `FIO_ADR_STAT
    |-> wbDatO[`FIO_STAT_ACTIVE] == $past(forceRunning))
    else $error("status bit disagrees with indicator");
endmodule : fio_override_properties

bind fio_override fio_override_properties chk (
  .clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
  .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .scan(scan),
  .sys(sys), .physIn(physIn), .progOut(progOut), .inImage(inImage),
  .outDrive(outDrive), .fastIn(fastIn), .stopReq(stopReq), .forceRunning(forceRunning));

// ===== verif/fio_tool_model.sv
// Purpose: Maintenance tool model issuing force commands over Wishbone
// Assumes: Classic single cycles, waits for ack without a count
// Notes: Tasks must be entered just after a rising edge
`timescale 1ns/1ps
`include "fio_defines.svh"

module fio_tool_model (
  input wire logic clk,
  output logic wbCyc,
  output logic wbStb,
  output logic wbWe,
  output logic [7:0] wbAdr,
  output logic [3:0] wbSel,
  output logic [31:0] wbDatI,
  input wire logic wbAck
);
  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hf;
    wbDatI = 32'h00000000;
  end

  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    // Stale write data would mask a slave that latches late
    wbDatI <= ~d;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, d, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(a, 32'h00000000, 1'b0);
  endtask : rd

  task automatic toggle;
    xfer(`FIO_ADR_CTRL, 32'h1 << `FIO_CTRL_TOGGLE, 1'b1);
  endtask : toggle

  task automatic releaseAll;
    xfer(`FIO_ADR_CTRL, 32'h1 << `FIO_CTRL_RELEASE_ALL, 1'b1);
  endtask : releaseAll

  task automatic download(input logic sus);
    xfer(`FIO_ADR_CTRL, sus ? 32'h30 : 32'h10, 1'b1);
  endtask : download
endmodule : fio_tool_model

// ===== verif/tb_fio_override.sv
// Purpose: Self-checking bench for the forced I/O override unit
// Assumes: Tool model drives the bus, bench drives scan and system
// Notes: Reads queue their expectation, a monitor compares on ack
`timescale 1ns/1ps
`include "fio_defines.svh"
`define CHK(n,e,s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, s); end end

module tb_fio_override
  import fio_pkg::*;
  ;
  logic clk, rst, wbCyc, wbStb, wbWe, wbAck, stopReq;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, ex;
  fio_scan_t scan;
  fio_sys_t sys;
  logic [`FIO_NUM_IN-1:0] physIn;
  logic [`FIO_NUM_OUT-1:0] progOut;
  logic [127:0] ph;
  logic [95:0] pg;
  logic [31:0] expQ[$];
  int n_fail, checks;

  fio_override dut (.clk(clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .scan(scan), .sys(sys), .physIn(physIn), .progOut(progOut), .inImage(),
    .outDrive(), .fastIn(), .stopReq(stopReq), .forceRunning());
  fio_tool_model tool (.clk(clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbAck(wbAck));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      ex = expQ.pop_front();
      `CHK($sformatf("read %h", wbAdr), ex, wbDatO)
    end
  end

  function automatic logic [31:0] img(logic [31:0] p, logic [31:0] d, logic [31:0] v);
    return (p & ~d) | (v & d);
  endfunction : img

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    tool.rd(a);
  endtask : rc

  task automatic refresh;
    scan.inRefresh <= 1'b1;
    scan.outRefresh <= 1'b1;
    @(posedge clk);
    scan.inRefresh <= 1'b0;
    scan.outRefresh <= 1'b0;
    @(posedge clk);
  endtask : refresh

  task automatic pwr(input logic bf);
    sys.powerUp <= 1'b1;
    sys.batteryFail <= bf;
    @(posedge clk);
    sys.powerUp <= 1'b0;
    @(posedge clk);
  endtask : pwr

  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    scan = '0;
    sys = '0;
    physIn = '0;
    progOut = '0;
    n_fail = 0;
    checks = 0;
    void'($urandom(38));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`FIO_ADR_STAT, 32'h0);
    rc(8'h80, 32'h0);
    // Point 2 is the reset input and must stay low or it erases everything
    ph = {$urandom, $urandom, $urandom, $urandom} & ~128'h4;
    pg = {$urandom, $urandom, $urandom};
    physIn <= ph[119:0];
    progOut <= pg[71:0];
    scan.running <= 1'b1;
    tool.wr(`FIO_ADR_IN_DESIG, 32'h11);
    tool.wr(`FIO_ADR_IN_VALUE, 32'h1);
    tool.wr(`FIO_ADR_OUT_DESIG, 32'h3);
    tool.wr(`FIO_ADR_OUT_VALUE, 32'h2);
    rc(`FIO_ADR_STAT, 32'h6);
    refresh();
    rc(`FIO_ADR_IN_IMAGE, ph[31:0]);
    rc(`FIO_ADR_OUT_IMAGE, pg[31:0]);
    tool.toggle();
    rc(`FIO_ADR_STAT, 32'h7);
    rc(`FIO_ADR_IN_IMAGE, ph[31:0]);
    refresh();
    rc(`FIO_ADR_IN_IMAGE, img(ph[31:0], 32'h11, 32'h1));
    rc(`FIO_ADR_OUT_IMAGE, img(pg[31:0], 32'h3, 32'h2));
    scan.running <= 1'b0;
    refresh();
    rc(`FIO_ADR_OUT_IMAGE, 32'h2);
    rc(`FIO_ADR_OUT_DESIG, 32'h3);
    tool.wr(`FIO_ADR_IN_DESIG, 32'h10);
    refresh();
    rc(`FIO_ADR_IN_IMAGE, img(ph[31:0], 32'h10, 32'h1));
    tool.wr(`FIO_ADR_IN_VALUE, 32'h5);
    tool.wr(`FIO_ADR_IN_DESIG, 32'h14);
    refresh();
    rc(`FIO_ADR_IN_DESIG, 32'h0);
    rc(`FIO_ADR_IN_VALUE, 32'h0);
    tool.wr(8'h1c, 32'hffffffff);
    tool.wr(8'h38, 32'hffffffff);
    rc(8'h1c, 32'h00ffffff);
    rc(8'h38, 32'h000000ff);
    tool.releaseAll();
    rc(8'h1c, 32'h0);
    rc(8'h38, 32'h0);
    // Forcing is active here; the stop point follows its pin until designated
    `CHK("stopReq", ph[1], stopReq)
    tool.wr(`FIO_ADR_IN_VALUE, {30'h0, ~ph[1], 1'b0});
    tool.wr(`FIO_ADR_IN_DESIG, 32'h2);
    `CHK("stopReq", ~ph[1], stopReq)
    tool.wr(`FIO_ADR_IN_DESIG, 32'h1);
    tool.download(1'b1);
    rc(`FIO_ADR_STAT, 32'h2);
    scan.maintainOutputsOnStopFlag <= 1'b1;
    refresh();
    tool.toggle();
    tool.download(1'b0);
    rc(`FIO_ADR_STAT, 32'h3);
    pwr(1'b0);
    rc(`FIO_ADR_STAT, 32'h2);
    rc(`FIO_ADR_IN_DESIG, 32'h1);
    pwr(1'b1);
    rc(`FIO_ADR_IN_DESIG, 32'h0);
    for (int k = 0; k < 3; k++) begin
      tool.wr(`FIO_ADR_IN_DESIG, 32'h1);
      if (k < 2) begin
        tool.wr(`FIO_ADR_CTRL, k == 0 ? 32'h4 : 32'h8);
      end else begin
        physIn[2] <= 1'b1;
        refresh();
        physIn[2] <= 1'b0;
      end
      rc(`FIO_ADR_IN_DESIG, 32'h0);
    end
    tool.wr(`FIO_ADR_OUT_DESIG, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`FIO_ADR_OUT_DESIG, 32'h0);
    rc(`FIO_ADR_STAT, 32'h0);
    wrap_up();
  end
endmodule : tb_fio_override
